// >>> mcr_pkg.sv
// mcr_pkg: constants and carriers for the auxiliary misc control register block.
// assumes: a single 125 MHz clock domain, APB slave with 32-bit data.
package mcr_pkg;

    // control register word index; its byte address is four times the index
    localparam logic [11:0] MISC_CONTROL_OFS = 12'h0A2;
    localparam logic [11:0] MISC_CONTROL_ADDR = {MISC_CONTROL_OFS[9:0], 2'b00};
    // other register byte addresses
    localparam logic [11:0] PTR0_ADDR = 12'h100;
    localparam logic [11:0] PTR1_ADDR = 12'h104;
    localparam logic [11:0] PTR_CUR_ADDR = 12'h108;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h10C;
    localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h110;
    localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h114;

    // misc_control field positions
    localparam int KEY_WAKE_BIT = 7;
    localparam int BROWNOUT_OFF_BIT = 6;
    localparam int BROWNOUT_IRQ_BIT = 5;
    localparam int LOW_POWER_PIN_BIT = 4;
    localparam int SOFT_RESTART_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int RESERVED_BIT = 1;
    localparam int POINTER_SELECT_BIT = 0;

    // reset values and writable mask (bits 2 and 3 never stored)
    localparam logic [7:0] MISC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MISC_CONTROL_WMASK = 8'hF3;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // interrupt status bit positions
    localparam int IRQ_KEY_BIT = 0;
    localparam int IRQ_BROWNOUT_BIT = 1;

    // soft restart pulse length in cycles
    localparam int RESTART_CYCLES = 4;

    // cpu pointer access commands
    typedef enum logic [2:0] {
        MCR_PTR_NONE = 3'h0,
        MCR_PTR_LOAD = 3'h1,
        MCR_PTR_INC = 3'h2,
        MCR_PTR_WR_LOW = 3'h3,
        MCR_PTR_WR_HIGH = 3'h4
    } mcr_ptr_cmd_t;

    // cpu-side pointer request carrier
    typedef struct packed {
        mcr_ptr_cmd_t cmd;
        logic [15:0] data;
    } mcr_ptr_req_t;

    // brownout control outputs
    typedef struct packed {
        logic detector_enable;
        logic reset_req;
        logic irq_req;
    } mcr_brownout_t;

endpackage : mcr_pkg

// >>> mcr_ptr_bank.sv
// mcr_ptr_bank: two 16-bit data pointers, one selected at a time.
// assumes: selection and commands come from the misc control block.
`timescale 1ns/1ps
module mcr_ptr_bank #(
    parameter int WIDTH = 16
) (
    input wire logic mclk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic sel, // pointer select
    input wire mcr_pkg::mcr_ptr_req_t req, // cpu pointer command
    input wire logic bus_wr0, // bus write to pointer 0
    input wire logic bus_wr1, // bus write to pointer 1
    input wire logic [WIDTH-1:0] bus_data, // bus write data
    output logic [WIDTH-1:0] ptr0, // pointer 0 value
    output logic [WIDTH-1:0] ptr1, // pointer 1 value
    output logic [WIDTH-1:0] cur // selected pointer
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] p;
    } mcr_bank_state_t;

    mcr_bank_state_t st_ff;
    mcr_bank_state_t nxt_st;

    // only the selected pointer is touched by cpu commands
    always_comb begin
        nxt_st = st_ff;
        case (req.cmd)
            mcr_pkg::MCR_PTR_LOAD: nxt_st.p[sel] = req.data;
            mcr_pkg::MCR_PTR_INC: nxt_st.p[sel] = st_ff.p[sel] + WIDTH'(1);
            mcr_pkg::MCR_PTR_WR_LOW: nxt_st.p[sel][7:0] = req.data[7:0];
            mcr_pkg::MCR_PTR_WR_HIGH: nxt_st.p[sel][WIDTH-1:8] = req.data[WIDTH-9:0];
            default: nxt_st = st_ff;
        endcase
        if (bus_wr0) begin
            nxt_st.p[0] = bus_data;
        end
        if (bus_wr1) begin
            nxt_st.p[1] = bus_data;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign ptr0 = st_ff.p[0];
    assign ptr1 = st_ff.p[1];
    assign cur = st_ff.p[sel];

endmodule : mcr_ptr_bank

// >>> mcr_misc_control.sv
// mcr_misc_control: auxiliary misc control register with dual pointer, brownout
// control, soft restart and key wake flag, reached over APB.
// assumes: APB master per protocol, synchronous inputs, key pins active low.
// Overview of operation
// - key_wake_flag sets when any enabled port 0 pin is low.
// - key_wake_flag stays set until software writes it zero.
// - brownout_off high disables the detector: no reset, no interrupt.
// - brownout_to_irq high blocks brownout from causing a chip reset.
// - with brownout_to_irq high, brownout raises an interrupt request instead.
// - writing bit 3 as one raises soft_restart for four cycles; this block's own registers keep their values.
// - bit 2 always reads zero and ignores writes.
// - bit 0 selects one of two pointers for cpu commands; apb reaches both.
// - cpu pointer commands act on selected pointer; apb PTR0/PTR1 writes ignore bit 0.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module mcr_misc_control #(
    parameter int PORT_W = 8,
    parameter int PTR_W = 16
) (
    input wire logic mclk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [PORT_W-1:0] port0_pins, // port 0 pin levels
    input wire logic [PORT_W-1:0] key_wake_enable, // per pin wake enable
    input wire logic brownout_detect, // raw brownout detect
    input wire mcr_pkg::mcr_ptr_req_t ptr_req, // cpu pointer command
    output logic [PTR_W-1:0] data_pointer, // selected pointer value
    output mcr_pkg::mcr_brownout_t brownout, // brownout controls
    output logic soft_restart, // chip restart request
    output logic irq // level interrupt
);

    typedef struct packed {
        logic [7:0] ctl;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic [2:0] restart_cnt;
        logic [31:0] rdata;
        logic err;
    } mcr_state_t;

    mcr_state_t st_ff;
    mcr_state_t nxt_st;

    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    logic acc;
    logic wr;
    logic [11:0] word_addr;
    logic key_event;
    logic bo_active;

    // word-aligned decode of one address
    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        hit = (a[11:2] == reg_addr[11:2]);
    endfunction : hit

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign word_addr = {paddr[11:2], 2'b00};
    assign key_event = |(key_wake_enable & ~port0_pins);
    assign bo_active = brownout_detect && !st_ff.ctl[mcr_pkg::BROWNOUT_OFF_BIT];

    // next state: register writes, flags, read mux
    always_comb begin
        nxt_st = st_ff;
        nxt_st.err = 1'b0;
        if (st_ff.restart_cnt != 3'h0) begin
            nxt_st.restart_cnt = st_ff.restart_cnt - 3'h1;
        end
        // interrupt status clear first, so a set below wins
        if (wr && hit(word_addr, mcr_pkg::IRQ_CLEAR_ADDR)) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[1:0];
        end
        if (wr && hit(word_addr, mcr_pkg::IRQ_ENABLE_ADDR)) begin
            nxt_st.irq_en = pwdata[1:0];
        end
        if (wr && hit(word_addr, mcr_pkg::MISC_CONTROL_ADDR)) begin
            // bits 2 and 3 never stored; 3 launches a restart
            nxt_st.ctl = pwdata[7:0] & mcr_pkg::MISC_CONTROL_WMASK;
            if (pwdata[mcr_pkg::SOFT_RESTART_BIT]) begin
                nxt_st.restart_cnt = 3'(mcr_pkg::RESTART_CYCLES);
            end
        end
        // hardware set wins over software clear
        if (key_event) begin
            nxt_st.ctl[mcr_pkg::KEY_WAKE_BIT] = 1'b1;
            nxt_st.irq_stat[mcr_pkg::IRQ_KEY_BIT] = 1'b1;
        end
        if (bo_active && st_ff.ctl[mcr_pkg::BROWNOUT_IRQ_BIT]) begin
            nxt_st.irq_stat[mcr_pkg::IRQ_BROWNOUT_BIT] = 1'b1;
        end
        // read data captured in setup phase
        nxt_st.rdata = 32'h0000_0000;
        if (psel && !penable) begin
            if (hit(paddr, mcr_pkg::MISC_CONTROL_ADDR)) begin
                nxt_st.rdata = {24'h000000, st_ff.ctl};
            end else if (hit(paddr, mcr_pkg::PTR0_ADDR)) begin
                nxt_st.rdata = {16'h0000, ptr0};
            end else if (hit(paddr, mcr_pkg::PTR1_ADDR)) begin
                nxt_st.rdata = {16'h0000, ptr1};
            end else if (hit(paddr, mcr_pkg::PTR_CUR_ADDR)) begin
                nxt_st.rdata = {16'h0000, data_pointer};
            end else if (hit(paddr, mcr_pkg::IRQ_STATUS_ADDR)) begin
                nxt_st.rdata = {30'h00000000, st_ff.irq_stat};
            end else if (hit(paddr, mcr_pkg::IRQ_ENABLE_ADDR)) begin
                nxt_st.rdata = {30'h00000000, st_ff.irq_en};
            end else if (!hit(paddr, mcr_pkg::IRQ_CLEAR_ADDR)) begin
                nxt_st.err = 1'b1;
            end else begin
                nxt_st.rdata = 32'h0000_0000;
            end
        end else if (psel && penable) begin
            nxt_st.rdata = st_ff.rdata;
            nxt_st.err = st_ff.err;
        end
    end

    // state register, all zero on reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pointer pair
    mcr_ptr_bank #(
        .WIDTH(PTR_W)
    ) u_ptr (
        .mclk(mclk),
        .rst_n(rst_n),
        .sel(st_ff.ctl[mcr_pkg::POINTER_SELECT_BIT]),
        .req(ptr_req),
        .bus_wr0(wr && hit(word_addr, mcr_pkg::PTR0_ADDR)),
        .bus_wr1(wr && hit(word_addr, mcr_pkg::PTR1_ADDR)),
        .bus_data(pwdata[PTR_W-1:0]),
        .ptr0(ptr0),
        .ptr1(ptr1),
        .cur(data_pointer)
    );

    // apb answers in the access cycle with no wait
    assign pready = 1'b1;
    assign prdata = st_ff.rdata;
    assign pslverr = acc && st_ff.err;

    // brownout routing
    assign brownout.detector_enable = !st_ff.ctl[mcr_pkg::BROWNOUT_OFF_BIT];
    assign brownout.reset_req = bo_active && !st_ff.ctl[mcr_pkg::BROWNOUT_IRQ_BIT];
    assign brownout.irq_req = bo_active && st_ff.ctl[mcr_pkg::BROWNOUT_IRQ_BIT];

    // restart pulse and interrupt level
    assign soft_restart = (st_ff.restart_cnt != 3'h0);
    assign irq = |(st_ff.irq_stat & st_ff.irq_en);

endmodule : mcr_misc_control

// >>> mcr_misc_control_checker.sv
// checker: port-level properties of the misc control block
// assumes: bound to mcr_misc_control, apb with zero wait states
`timescale 1ns/1ps
module mcr_misc_control_checker #(parameter int PORT_W = 8, parameter int PTR_W = 16) (
    input wire logic mclk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [PORT_W-1:0] port0_pins, // pin levels
    input wire logic [PORT_W-1:0] key_wake_enable, // wake enables
    input wire logic brownout_detect, // raw detect
    input wire mcr_pkg::mcr_ptr_req_t ptr_req, // pointer command
    input wire logic [PTR_W-1:0] data_pointer, // selected pointer
    input wire mcr_pkg::mcr_brownout_t brownout, // brownout controls
    input wire logic soft_restart, // restart request
    input wire logic irq // level interrupt
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // key pin low, then a control read set up right after
    sequence s_key_rd;
        |(key_wake_enable & ~port0_pins)
        ##1 psel && !penable && !pwrite && paddr == mcr_pkg::MISC_CONTROL_ADDR;
    endsequence
    sequence s_rst_wr;
        psel && penable && pwrite && paddr == mcr_pkg::MISC_CONTROL_ADDR && pwdata[3];
    endsequence
    property p_key; s_key_rd ##1 penable |-> prdata[7]; endproperty
    a_key: assert property (p_key) else $error("key flag not set");
    property p_sticky; irq && !(psel && penable && pwrite) |=> irq; endproperty
    a_sticky: assert property (p_sticky) else $error("irq dropped by itself");
    property p_off; !brownout.detector_enable |-> !brownout.reset_req && !brownout.irq_req; endproperty
    a_off: assert property (p_off) else $error("disabled detector acts");
    property p_irq;
        brownout_detect && brownout.detector_enable && !brownout.reset_req |-> brownout.irq_req;
    endproperty
    a_irq: assert property (p_irq) else $error("brownout lost");
    property p_restart; s_rst_wr |=> soft_restart[*4] ##1 !soft_restart; endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    property p_zero;
        psel && penable && !pwrite && paddr == mcr_pkg::MISC_CONTROL_ADDR |-> prdata[3:2] == 2'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("bits 3..2 not zero");
    property p_load;
        ptr_req.cmd == mcr_pkg::MCR_PTR_LOAD && !psel |=> data_pointer == $past(ptr_req.data);
    endproperty
    a_load: assert property (p_load) else $error("load missed pointer");
    property p_rst;
        $rose(rst_n) |-> data_pointer == '0 && !soft_restart && !irq && prdata == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared");
endmodule : mcr_misc_control_checker
bind mcr_misc_control mcr_misc_control_checker #(
    .PORT_W(PORT_W),
    .PTR_W(PTR_W)
) i_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .port0_pins(port0_pins),
    .key_wake_enable(key_wake_enable),
    .brownout_detect(brownout_detect),
    .ptr_req(ptr_req),
    .data_pointer(data_pointer),
    .brownout(brownout),
    .soft_restart(soft_restart),
    .irq(irq)
);

// >>> mcr_misc_control_bench.sv
// bench: directed tests of the misc control block
// assumes: apb slave answers through pready, checker bound separately
`timescale 1ns/1ps
module mcr_misc_control_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, brownout_detect = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, soft_restart, irq, err;
    logic [7:0] port0_pins = 8'hFF, key_wake_enable = 8'h01;
    mcr_pkg::mcr_ptr_req_t ptr_req = '0;
    logic [15:0] data_pointer;
    mcr_pkg::mcr_brownout_t brownout;
    int n_errors = 0, num_checks = 0;
    localparam logic [11:0] CTL = mcr_pkg::MISC_CONTROL_ADDR;
    mcr_misc_control i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0_pins(port0_pins), .key_wake_enable(key_wake_enable),
        .brownout_detect(brownout_detect), .ptr_req(ptr_req), .data_pointer(data_pointer),
        .brownout(brownout), .soft_restart(soft_restart), .irq(irq));
    // 8 ns clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    // one apb transfer, answer taken at the edge with pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one pointer command for one cycle
    task automatic pcmd(input mcr_pkg::mcr_ptr_cmd_t c, input logic [15:0] d);
        @(posedge mclk);
        ptr_req <= '{cmd: c, data: d};
        @(posedge mclk);
        ptr_req <= '0;
        @(negedge mclk);
    endtask : pcmd
    task automatic t_regs;
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, CTL, 32'hFD);
        @(negedge mclk);
        chk(32'(soft_restart), 32'h1);
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'hF1);
        apb(1'b0, 12'h200, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, CTL, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_brown;
        brownout_detect <= 1'b1;
        apb(1'b1, CTL, 32'h40);
        @(negedge mclk);
        chk(32'(brownout), 32'h0);
        apb(1'b1, CTL, 32'h20);
        @(negedge mclk);
        chk(32'(brownout), 32'h5);
        apb(1'b0, mcr_pkg::IRQ_STATUS_ADDR, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, CTL, 32'h0);
        @(negedge mclk);
        chk(32'(brownout), 32'h6);
        brownout_detect <= 1'b0;
        apb(1'b1, mcr_pkg::IRQ_CLEAR_ADDR, 32'h3);
        $display("test brownout done");
    endtask : t_brown
    task automatic t_key;
        apb(1'b1, mcr_pkg::IRQ_ENABLE_ADDR, 32'h1);
        port0_pins <= 8'hFD;
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'h0);
        port0_pins <= 8'hFE;
        apb(1'b0, CTL, 32'h0);
        chk(rd, 32'h80);
        port0_pins <= 8'hFF;
        repeat (20) @(posedge mclk);
        apb(1'b0, CTL, 32'h0);
        chk({rd[31:1], irq}, 32'h81);
        apb(1'b1, CTL, 32'h0);
        apb(1'b1, mcr_pkg::IRQ_CLEAR_ADDR, 32'h1);
        apb(1'b0, CTL, 32'h0);
        chk({rd[31:1], irq}, 32'h0);
        $display("test key done");
    endtask : t_key
    task automatic t_ptr;
        pcmd(mcr_pkg::MCR_PTR_LOAD, 16'h1234);
        apb(1'b1, CTL, 32'h1);
        @(negedge mclk);
        chk(32'(data_pointer), 32'h0);
        pcmd(mcr_pkg::MCR_PTR_INC, 16'h0000);
        pcmd(mcr_pkg::MCR_PTR_WR_HIGH, 16'h00CD);
        chk(32'(data_pointer), 32'hCD01);
        apb(1'b1, CTL, 32'h0);
        pcmd(mcr_pkg::MCR_PTR_WR_LOW, 16'h00AB);
        chk(32'(data_pointer), 32'h12AB);
        apb(1'b0, mcr_pkg::PTR1_ADDR, 32'h0);
        chk(rd, 32'hCD01);
        $display("test pointer done");
    endtask : t_ptr
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_brown();
        t_key();
        t_ptr();
        final_report();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        final_report();
    end
endmodule : mcr_misc_control_bench
